// file: logic/dsc_pkg.sv
// Constants shared by the decimal string conversion unit.
// Assumes a 32-bit APB register bus and a byte-wide memory port.
package dsc_pkg;
  // Operation codes held in the opcode register.
  localparam logic [7:0] OP_PACKED_TO_LEADING_SEPARATE = 8'h08;
  localparam logic [7:0] OP_LEADING_SEPARATE_TO_PACKED = 8'h09;
  localparam logic [7:0] OP_PACKED_TO_TRAILING_NUMERIC = 8'h24;
  localparam logic [7:0] OP_TRAILING_NUMERIC_TO_PACKED = 8'h26;
  // Character codes.
  localparam logic [7:0] CH_PLUS = 8'h2B;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;
  // Packed sign and digit nibbles.
  localparam logic [3:0] NIB_PLUS = 4'hC;
  localparam logic [3:0] NIB_MINUS = 4'hD;
  localparam logic [3:0] NIB_MINUS_ALT = 4'hB;
  localparam logic [3:0] NIB_SIGN_LOW = 4'hA;
  localparam logic [3:0] NIB_DIGIT_MAX = 4'h9;
  localparam logic [15:0] MAX_LEN = 16'h001F;
  // Register byte offsets.
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_OPCODE = 8'h04;
  localparam logic [7:0] A_SRC_LEN = 8'h08;
  localparam logic [7:0] A_SRC_ADDR = 8'h0C;
  localparam logic [7:0] A_TBL_ADDR = 8'h10;
  localparam logic [7:0] A_DST_LEN = 8'h14;
  localparam logic [7:0] A_DST_ADDR = 8'h18;
  localparam logic [7:0] A_STATUS = 8'h1C;
  localparam logic [7:0] A_GR0 = 8'h20;
  localparam logic [7:0] A_GR1 = 8'h24;
  localparam logic [7:0] A_GR2 = 8'h28;
  localparam logic [7:0] A_GR3 = 8'h2C;
  // Field positions.
  localparam int CTRL_GO = 0;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_RESOP = 2;
  localparam int ST_C = 4;
  localparam int ST_V = 5;
  localparam int ST_Z = 6;
  localparam int ST_N = 7;
  // Reset values.
  localparam logic [7:0] OPCODE_RESET = 8'h00;
  localparam logic [15:0] LEN_RESET = 16'h0000;

  typedef enum logic [2:0] {
    DSC_IDLE = 3'b000,
    DSC_READ = 3'b001,
    DSC_TABLE = 3'b010,
    DSC_WRITE = 3'b011,
    DSC_FINISH = 3'b100
  } dsc_state_type;
endpackage

// file: logic/dsc_unit.sv
// Decimal string conversion unit: four conversions between packed
// decimal and numeric strings, with APB registers and a byte memory port.
// Assumes memory answers each held mem_req with a one-cycle mem_ack.
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module dsc_unit #(
  parameter int AW = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_req,
  output logic mem_we,
  output logic [AW-1:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack
);
  if (AW < 8 || AW > 32) begin : g_aw_check
    $error("dsc_unit: AW must lie between 8 and 32");
  end

  logic [7:0] opcode;
  logic [15:0] src_len;
  logic [15:0] dst_len;
  logic [AW-1:0] src_addr;
  logic [AW-1:0] tbl_addr;
  logic [AW-1:0] dst_addr;
  logic [AW-1:0] gr1;
  logic [AW-1:0] gr3;
  logic done, resop, flag_n, flag_z, flag_v, flag_c;
  dsc_pkg::dsc_state_type state;
  logic [5:0] cnt;
  logic [7:0] tbyte;
  logic [7:0] sbuf [0:31];
  logic [3:0] dig [0:31];
  logic [4:0] slen, dlen;
  logic to_packed, packed_src, op_ok, len_bad;
  logic [5:0] nsrc, ndst;
  logic wr_en, start, src_zero, dst_zero, ovf, neg;
  logic need_tbl, byte_bad, tbl_bad;
  logic [7:0] obyte;
  logic [31:0] rd_mux;
  logic rd_hit;

  function automatic logic is_digit(input logic [7:0] b);
    return b >= dsc_pkg::CH_ZERO && b <= dsc_pkg::CH_NINE;
  endfunction

  function automatic logic is_minus(input logic [3:0] n);
    return n == dsc_pkg::NIB_MINUS || n == dsc_pkg::NIB_MINUS_ALT;
  endfunction

  function automatic logic [7:0] to_char(input logic [3:0] d);
    return dsc_pkg::CH_ZERO | {4'h0, d};
  endfunction

  assign slen = src_len[4:0];
  assign dlen = dst_len[4:0];
  assign packed_src =
    opcode == dsc_pkg::OP_PACKED_TO_LEADING_SEPARATE ||
    opcode == dsc_pkg::OP_PACKED_TO_TRAILING_NUMERIC;
  assign to_packed =
    opcode == dsc_pkg::OP_LEADING_SEPARATE_TO_PACKED ||
    opcode == dsc_pkg::OP_TRAILING_NUMERIC_TO_PACKED;
  assign op_ok = packed_src || to_packed;
  assign len_bad = src_len > dsc_pkg::MAX_LEN ||
    dst_len > dsc_pkg::MAX_LEN;

  // Byte counts of the source and destination strings.
  always_comb begin
    case (opcode)
      dsc_pkg::OP_PACKED_TO_LEADING_SEPARATE: begin
        nsrc = {2'b00, slen[4:1]} + 6'h01;
        ndst = {1'b0, dlen} + 6'h01;
      end
      dsc_pkg::OP_PACKED_TO_TRAILING_NUMERIC: begin
        nsrc = {2'b00, slen[4:1]} + 6'h01;
        ndst = {1'b0, dlen};
      end
      dsc_pkg::OP_LEADING_SEPARATE_TO_PACKED: begin
        nsrc = {1'b0, slen} + 6'h01;
        ndst = {2'b00, dlen[4:1]} + 6'h01;
      end
      default: begin
        nsrc = {1'b0, slen};
        ndst = {2'b00, dlen[4:1]} + 6'h01;
      end
    endcase
  end

  assign need_tbl = opcode == dsc_pkg::OP_PACKED_TO_TRAILING_NUMERIC ||
    (opcode == dsc_pkg::OP_TRAILING_NUMERIC_TO_PACKED &&
    slen != 5'h00);

  // Source digits, least significant first, zero beyond the length.
  always_comb begin
    int k;
    k = 0;
    for (int j = 0; j < 32; j++) begin
      dig[j] = 4'h0;
      if (j < int'(slen)) begin
        if (packed_src) begin
          k = int'(slen[4:1]) - (j + 1) / 2;
          dig[j] = (j % 2 == 1) ? sbuf[k[4:0]][3:0] : sbuf[k[4:0]][7:4];
        end else if (opcode == dsc_pkg::OP_LEADING_SEPARATE_TO_PACKED) begin
          k = int'(slen) - j;
          dig[j] = sbuf[k[4:0]][3:0];
        end else if (j == 0) begin
          dig[j] = tbyte[7:4];
        end else begin
          k = int'(slen) - 1 - j;
          dig[j] = sbuf[k[4:0]][3:0];
        end
      end
    end
  end

  // Zero and overflow tests against the destination length.
  always_comb begin
    src_zero = 1'b1;
    dst_zero = 1'b1;
    ovf = 1'b0;
    for (int j = 0; j < 32; j++) begin
      if (dig[j] != 4'h0) begin
        src_zero = 1'b0;
        if (j < int'(dlen)) begin
          dst_zero = 1'b0;
        end else begin
          ovf = 1'b1;
        end
      end
    end
  end

  always_comb begin
    case (opcode)
      dsc_pkg::OP_LEADING_SEPARATE_TO_PACKED:
        neg = sbuf[0] == dsc_pkg::CH_MINUS;
      dsc_pkg::OP_TRAILING_NUMERIC_TO_PACKED:
        neg = slen != 5'h00 && is_minus(tbyte[3:0]);
      default:
        neg = is_minus(sbuf[slen[4:1]][3:0]);
    endcase
  end

  // Validity of an arriving source byte.
  always_comb begin
    byte_bad = 1'b0;
    if (opcode == dsc_pkg::OP_LEADING_SEPARATE_TO_PACKED) begin
      if (cnt == 6'h00) begin
        byte_bad = !(mem_rdata == dsc_pkg::CH_PLUS ||
          mem_rdata == dsc_pkg::CH_SPACE ||
          mem_rdata == dsc_pkg::CH_MINUS);
      end else begin
        byte_bad = !is_digit(mem_rdata);
      end
    end else if (opcode == dsc_pkg::OP_TRAILING_NUMERIC_TO_PACKED) begin
      byte_bad = cnt != nsrc - 6'h01 && !is_digit(mem_rdata);
    end
  end

  assign tbl_bad = opcode == dsc_pkg::OP_TRAILING_NUMERIC_TO_PACKED &&
    (mem_rdata[7:4] > dsc_pkg::NIB_DIGIT_MAX ||
    mem_rdata[3:0] < dsc_pkg::NIB_SIGN_LOW);

  // Destination byte for the current write position.
  always_comb begin
    int hi, lo;
    hi = 0;
    lo = 0;
    obyte = 8'h00;
    case (opcode)
      dsc_pkg::OP_PACKED_TO_LEADING_SEPARATE: begin
        hi = int'(dlen) - int'(cnt);
        if (cnt == 6'h00) begin
          obyte = (neg && !src_zero) ? dsc_pkg::CH_MINUS
            : dsc_pkg::CH_PLUS;
        end else begin
          obyte = to_char(dig[hi[4:0]]);
        end
      end
      dsc_pkg::OP_PACKED_TO_TRAILING_NUMERIC: begin
        hi = int'(dlen) - 1 - int'(cnt);
        if (hi == 0) begin
          obyte = tbyte;
        end else begin
          obyte = to_char(dig[hi[4:0]]);
        end
      end
      default: begin
        hi = 2 * (int'(dlen[4:1]) - int'(cnt));
        lo = hi - 1;
        if (hi < int'(dlen)) begin
          obyte[7:4] = dig[hi[4:0]];
        end
        if (lo < 0) begin
          obyte[3:0] = (neg && !dst_zero) ? dsc_pkg::NIB_MINUS
            : dsc_pkg::NIB_PLUS;
        end else if (lo < int'(dlen)) begin
          obyte[3:0] = dig[lo[4:0]];
        end
      end
    endcase
  end

  // APB decode; every access completes without wait states.
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign start = wr_en && paddr == dsc_pkg::A_CTRL &&
    pwdata[dsc_pkg::CTRL_GO] && state == dsc_pkg::DSC_IDLE;

  // Operand registers are frozen while a conversion runs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opcode <= dsc_pkg::OPCODE_RESET;
      src_len <= dsc_pkg::LEN_RESET;
      dst_len <= dsc_pkg::LEN_RESET;
      src_addr <= '0;
      tbl_addr <= '0;
      dst_addr <= '0;
    end else if (wr_en && state == dsc_pkg::DSC_IDLE) begin
      case (paddr)
        dsc_pkg::A_OPCODE: opcode <= pwdata[7:0];
        dsc_pkg::A_SRC_LEN: src_len <= pwdata[15:0];
        dsc_pkg::A_DST_LEN: dst_len <= pwdata[15:0];
        dsc_pkg::A_SRC_ADDR: src_addr <= pwdata[AW-1:0];
        dsc_pkg::A_TBL_ADDR: tbl_addr <= pwdata[AW-1:0];
        dsc_pkg::A_DST_ADDR: dst_addr <= pwdata[AW-1:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      dsc_pkg::A_CTRL: rd_mux = 32'h0000_0000;
      dsc_pkg::A_OPCODE: rd_mux[7:0] = opcode;
      dsc_pkg::A_SRC_LEN: rd_mux[15:0] = src_len;
      dsc_pkg::A_DST_LEN: rd_mux[15:0] = dst_len;
      dsc_pkg::A_SRC_ADDR: rd_mux[AW-1:0] = src_addr;
      dsc_pkg::A_TBL_ADDR: rd_mux[AW-1:0] = tbl_addr;
      dsc_pkg::A_DST_ADDR: rd_mux[AW-1:0] = dst_addr;
      dsc_pkg::A_GR0: rd_mux = 32'h0000_0000;
      dsc_pkg::A_GR2: rd_mux = 32'h0000_0000;
      dsc_pkg::A_GR1: rd_mux[AW-1:0] = gr1;
      dsc_pkg::A_GR3: rd_mux[AW-1:0] = gr3;
      dsc_pkg::A_STATUS: begin
        rd_mux[dsc_pkg::ST_BUSY] = state != dsc_pkg::DSC_IDLE;
        rd_mux[dsc_pkg::ST_DONE] = done;
        rd_mux[dsc_pkg::ST_RESOP] = resop;
        rd_mux[dsc_pkg::ST_C] = flag_c;
        rd_mux[dsc_pkg::ST_V] = flag_v;
        rd_mux[dsc_pkg::ST_Z] = flag_z;
        rd_mux[dsc_pkg::ST_N] = flag_n;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // Read data and error are captured in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= !rd_hit;
    end
  end

  // Source byte buffer, filled as read data arrives.
  always_ff @(posedge pclk) begin
    if (state == dsc_pkg::DSC_READ && mem_req && mem_ack) begin
      sbuf[cnt[4:0]] <= mem_rdata;
    end
  end

  // Conversion sequencer and memory port.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= dsc_pkg::DSC_IDLE;
      cnt <= 6'h00;
      tbyte <= 8'h00;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= '0;
      mem_wdata <= 8'h00;
      done <= 1'b0;
      resop <= 1'b0;
      flag_n <= 1'b0;
      flag_z <= 1'b0;
      flag_v <= 1'b0;
      flag_c <= 1'b0;
      gr1 <= '0;
      gr3 <= '0;
    end else begin
      case (state)
        dsc_pkg::DSC_IDLE: begin
          if (start) begin
            done <= 1'b0;
            resop <= 1'b0;
            cnt <= 6'h00;
            if (len_bad || !op_ok) begin
              resop <= 1'b1;
              done <= 1'b1;
            end else if (nsrc == 6'h00) begin
              state <= dsc_pkg::DSC_WRITE;
            end else begin
              state <= dsc_pkg::DSC_READ;
            end
          end
        end
        dsc_pkg::DSC_READ: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= src_addr + AW'(cnt);
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            cnt <= cnt + 6'h01;
            if (byte_bad) begin
              resop <= 1'b1;
              done <= 1'b1;
              state <= dsc_pkg::DSC_IDLE;
            end else if (cnt == nsrc - 6'h01) begin
              cnt <= 6'h00;
              state <= need_tbl ? dsc_pkg::DSC_TABLE
                : dsc_pkg::DSC_WRITE;
            end
          end
        end
        dsc_pkg::DSC_TABLE: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= tbl_addr + AW'(sbuf[nsrc[4:0] - 5'h01]);
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            tbyte <= mem_rdata;
            if (tbl_bad) begin
              resop <= 1'b1;
              done <= 1'b1;
              state <= dsc_pkg::DSC_IDLE;
            end else if (ndst == 6'h00) begin
              state <= dsc_pkg::DSC_FINISH;
            end else begin
              state <= dsc_pkg::DSC_WRITE;
            end
          end
        end
        dsc_pkg::DSC_WRITE: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_addr <= dst_addr + AW'(cnt);
            mem_wdata <= obyte;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            cnt <= cnt + 6'h01;
            if (cnt == ndst - 6'h01) begin
              state <= dsc_pkg::DSC_FINISH;
            end
          end
        end
        dsc_pkg::DSC_FINISH: begin
          gr1 <= src_addr;
          gr3 <= dst_addr;
          flag_v <= ovf;
          flag_c <= 1'b0;
          if (to_packed) begin
            flag_z <= dst_zero;
            flag_n <= neg && !dst_zero;
          end else begin
            flag_z <= src_zero;
            flag_n <= neg && !src_zero;
          end
          done <= 1'b1;
          state <= dsc_pkg::DSC_IDLE;
        end
        default: state <= dsc_pkg::DSC_IDLE;
      endcase
    end
  end
endmodule

// file: sim/dsc_mem_model.sv
// Byte memory standing behind the conversion unit's memory port.
// Assumes one held request at a time; answers after lat idle cycles.
`timescale 1ns/10ps
module dsc_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic [3:0] lat,
  output logic [7:0] mem_rdata,
  output logic mem_ack
);
  logic [7:0] mem [0:1023];
  int cnt;
  int tbl_reads = 0;
  // Read data is scrambled outside the answer cycle so stale use shows.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      cnt <= 0;
      mem_rdata <= 8'hA5;
    end else if (mem_req && !mem_ack && cnt >= lat) begin
      mem_ack <= 1'b1;
      cnt <= 0;
      if (mem_we) mem[mem_addr[9:0]] <= mem_wdata;
      else mem_rdata <= mem[mem_addr[9:0]];
      if (!mem_we && mem_addr[9:8] == 2'h2) tbl_reads <= tbl_reads + 1;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      // Only waiting cycles count, so every request sees the full latency.
      if (mem_req && !mem_ack) cnt <= cnt + 1;
    end
  end
endmodule

// file: sim/dsc_unit_sva.sv
// Port checker for the decimal string conversion unit.
// Assumes it is bound to dsc_unit and that operands change only when idle.
`timescale 1ns/10ps
module dsc_unit_sva #(
  parameter int AW = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [AW-1:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack
);
  logic [7:0] op_q;
  logic [15:0] sl_q;
  logic [15:0] dl_q;
  logic [AW-1:0] da_q;
  wire logic apw = psel && penable && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q <= 8'h00;
      sl_q <= 16'h0000;
      dl_q <= 16'h0000;
      da_q <= '0;
    end else if (apw) begin
      if (paddr == dsc_pkg::A_OPCODE) op_q <= pwdata[7:0];
      if (paddr == dsc_pkg::A_SRC_LEN) sl_q <= pwdata[15:0];
      if (paddr == dsc_pkg::A_DST_LEN) dl_q <= pwdata[15:0];
      if (paddr == dsc_pkg::A_DST_ADDR) da_q <= pwdata[AW-1:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_taken;
    mem_req && mem_ack;
  endsequence
  sequence s_wr(logic [7:0] op);
    mem_req && mem_we && op_q == op;
  endsequence
  sequence s_rd(logic [7:0] a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req &&
    $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata))
    else $error("memory request changed before its answer");
  mem_gap_a: assert property (s_taken |=> !mem_req)
    else $error("memory request not dropped after answer");
  sign_byte_a: assert property (
    s_wr(dsc_pkg::OP_PACKED_TO_LEADING_SEPARATE) ##0 mem_addr == da_q
    |-> mem_wdata == dsc_pkg::CH_PLUS || mem_wdata == dsc_pkg::CH_MINUS)
    else $error("sign byte is not a plus or minus character");
  digit_byte_a: assert property (
    s_wr(dsc_pkg::OP_PACKED_TO_LEADING_SEPARATE) ##0 mem_addr != da_q
    |-> mem_wdata >= dsc_pkg::CH_ZERO && mem_wdata <= dsc_pkg::CH_NINE)
    else $error("digit byte is not a digit character");
  no_table_a: assert property (
    op_q == dsc_pkg::OP_TRAILING_NUMERIC_TO_PACKED && sl_q == 16'h0000
    && mem_req |-> mem_we)
    else $error("read issued for empty trailing source");
  bad_len_a: assert property (
    op_q == dsc_pkg::OP_LEADING_SEPARATE_TO_PACKED && (sl_q >
    dsc_pkg::MAX_LEN || dl_q > dsc_pkg::MAX_LEN) |-> !mem_req)
    else $error("memory touched with length out of range");
  carry_clr_a: assert property (
    s_rd(dsc_pkg::A_STATUS) |-> !prdata[dsc_pkg::ST_C])
    else $error("carry flag set");
  gr0_zero_a: assert property (s_rd(dsc_pkg::A_GR0) |-> prdata == 0)
    else $error("general register 0 not zero");
  gr2_zero_a: assert property (s_rd(dsc_pkg::A_GR2) |-> prdata == 0)
    else $error("general register 2 not zero");
  unmapped_a: assert property (psel && penable && paddr > dsc_pkg::A_GR3
    |-> pslverr && pready)
    else $error("unmapped access without error response");
endmodule

// file: sim/dsc_unit_tb_top.sv
// Self-checking bench for the decimal string conversion unit.
// Assumes the byte memory model and the port checker alongside.
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin \
  num_errors++; $display("CHECK FAILED %s exp %0h got %0h", nm, ex, gt); \
  end end
module dsc_unit_tb_top;
  typedef struct {logic [7:0] op; int sl; int dl; logic [39:0] s; int ne;
    logic [31:0] e; logic [3:0] f; int tr;} dsc_row_type;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic mem_req, mem_we, mem_ack;
  logic [7:0] paddr, mem_wdata, mem_rdata;
  logic [31:0] pwdata, prdata, mem_addr, q;
  logic [3:0] lat;
  logic e;
  int num_errors = 0;
  int n_checks = 0;
  dsc_row_type rows [17];
  dsc_unit dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack));
  dsc_mem_model mem_i (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .lat(lat),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  always #10 pclk = ~pclk;
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic run(input int i, input logic bz);
    dsc_row_type r;
    int k;
    int n;
    int t0;
    r = rows[i];
    n = (r.op == dsc_pkg::OP_LEADING_SEPARATE_TO_PACKED) ? r.sl + 1 :
      (r.op == dsc_pkg::OP_TRAILING_NUMERIC_TO_PACKED) ? r.sl : r.sl / 2 + 1;
    if (n > 5) n = 5;
    for (k = 0; k < n; k++) mem_i.mem[256 + k] = r.s[8 * (n - 1 - k) +: 8];
    for (k = 0; k < 4; k++) mem_i.mem[768 + k] = 8'hEE;
    t0 = mem_i.tbl_reads;
    apb(1'b1, dsc_pkg::A_OPCODE, {24'h000000, r.op});
    apb(1'b1, dsc_pkg::A_SRC_LEN, 32'(r.sl));
    apb(1'b1, dsc_pkg::A_SRC_ADDR, 32'h00000100);
    apb(1'b1, dsc_pkg::A_TBL_ADDR, 32'h00000200);
    apb(1'b1, dsc_pkg::A_DST_LEN, 32'(r.dl));
    apb(1'b1, dsc_pkg::A_DST_ADDR, 32'h00000300);
    apb(1'b1, dsc_pkg::A_CTRL, 32'h00000001);
    // Operand and start writes while busy must be ignored.
    if (bz) apb(1'b1, dsc_pkg::A_OPCODE, 32'h00000026);
    if (bz) apb(1'b1, dsc_pkg::A_CTRL, 32'h00000001);
    q = 32'h00000000;
    while (q[dsc_pkg::ST_DONE] !== 1'b1) apb(1'b0, dsc_pkg::A_STATUS, 0);
    `CHK("resop", r.f[0], q[dsc_pkg::ST_RESOP])
    if (!r.f[0]) begin
      `CHK("n", r.f[3], q[dsc_pkg::ST_N])
      `CHK("z", r.f[2], q[dsc_pkg::ST_Z])
      `CHK("v", r.f[1], q[dsc_pkg::ST_V])
      apb(1'b0, dsc_pkg::A_GR0, 0);
      `CHK("gr0", 32'h00000000, q)
      apb(1'b0, dsc_pkg::A_GR2, 0);
      `CHK("gr2", 32'h00000000, q)
      apb(1'b0, dsc_pkg::A_GR1, 0);
      `CHK("gr1", 32'h00000100, q)
      apb(1'b0, dsc_pkg::A_GR3, 0);
      `CHK("gr3", 32'h00000300, q)
      for (k = 0; k < r.ne; k++)
        `CHK("dst", r.e[8 * (r.ne - 1 - k) +: 8], mem_i.mem[768 + k])
      if (r.tr >= 0) `CHK("tbl", r.tr, mem_i.tbl_reads - t0)
    end
  endtask
  initial begin
    repeat (50000) @(posedge pclk);
    num_errors++;
    complete_run();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    lat = 4'h0;
    rows[0] = '{8'h08, 3, 3, 40'h123D, 4, 32'h2D313233, 4'h8, -1};
    rows[1] = '{8'h08, 1, 1, 40'h0D, 2, 32'h2B30, 4'h4, -1};
    rows[2] = '{8'h08, 3, 2, 40'h123C, 0, 32'h0, 4'h2, -1};
    rows[3] = '{8'h24, 3, 3, 40'h123C, 3, 32'h3132CA, 4'h0, 1};
    rows[4] = '{8'h24, 3, 0, 40'h123D, 0, 32'h0, 4'hA, 1};
    rows[5] = '{8'h24, 1, 1, 40'h0D, 1, 32'hDA, 4'h4, 1};
    rows[6] = '{8'h09, 3, 3, 40'h2D303435, 2, 32'h045D, 4'h8, -1};
    rows[7] = '{8'h09, 1, 1, 40'h2037, 1, 32'h7C, 4'h0, -1};
    rows[8] = '{8'h26, 2, 2, 40'h3375, 2, 32'h035D, 4'h8, 1};
    rows[9] = '{8'h26, 1, 1, 40'h70, 1, 32'h0C, 4'h4, 1};
    rows[10] = '{8'h26, 0, 1, 40'h0, 1, 32'h0C, 4'h4, 0};
    rows[11] = '{8'h09, 32, 1, 40'h2B31, 0, 32'h0, 4'h1, -1};
    rows[12] = '{8'h09, 1, 32, 40'h2B31, 0, 32'h0, 4'h1, -1};
    rows[13] = '{8'h09, 1, 1, 40'h2A31, 0, 32'h0, 4'h1, -1};
    rows[14] = '{8'h09, 1, 1, 40'h2B3A, 0, 32'h0, 4'h1, -1};
    rows[15] = '{8'h26, 2, 1, 40'h4135, 0, 32'h0, 4'h1, -1};
    rows[16] = '{8'h26, 1, 1, 40'h3A, 0, 32'h0, 4'h1, -1};
    // Table entry: digit from the low nibble, sign nibble A or B.
    for (int i = 0; i < 256; i++)
      mem_i.mem[512 + i] = {i[3:0], (i[7:4] == 4'h7) ? 4'hB : 4'hA};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 17; i++) begin
      lat <= 4'(i % 3);
      run(i, 1'b0);
    end
    lat <= 4'h6;
    run(0, 1'b1);
    apb(1'b0, 8'h30, 0);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h00000000, q)
    apb(1'b1, dsc_pkg::A_CTRL, 32'h00000001);
    repeat (3) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, dsc_pkg::A_STATUS, 0);
    `CHK("status reset", 32'h00000000, q)
    apb(1'b0, dsc_pkg::A_OPCODE, 0);
    `CHK("opcode reset", 32'h00000000, q)
    complete_run();
  end
endmodule
bind dsc_unit dsc_unit_sva #(.AW(AW)) u_sva (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
